// ==== rtl/fkx_apb_regs.sv ====
// APB slave with control and status registers.
// Assumes APB3 signalling; one wait-free access phase.
`default_nettype none
module fkx_apb_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [15:0] key_count,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic [31:0] ctrl_q
);
  logic hit;
  always_comb
  begin
    if (paddr == fkx_pkg::CTRL_OFS)
      hit = 1'b1;
    else if (paddr == fkx_pkg::STAT_OFS)
      hit = 1'b1;
    else
      hit = 1'b0;
  end
  // Answer is prepared in the setup cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (psel && !penable && !pwrite && paddr == fkx_pkg::CTRL_OFS)
        prdata <= ctrl_q & 32'h0000_000F;
      else if (psel && !penable && !pwrite && paddr == fkx_pkg::STAT_OFS)
        prdata <= {16'h0000, key_count};
      else
        prdata <= 32'h0000_0000;
    end
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_q <= fkx_pkg::CTRL_RST;
    else if (psel && penable && pready && pwrite &&
             paddr == fkx_pkg::CTRL_OFS)
      ctrl_q <= pwdata & 32'h0000_000F;
  end
endmodule : fkx_apb_regs
`default_nettype wire

// ==== rtl/fkx_classify.sv ====
// Combinational frame type flags and overloaded key fields.
// Assumes parser fields are stable while in_valid is high.
`default_nettype none
module fkx_classify (
  input wire logic [15:0] type_len,
  input wire logic [3:0] ip_version,
  input wire logic [23:0] llc_hdr,
  input wire logic [7:0] ip4_proto,
  input wire logic [7:0] ip6_next_hdr,
  input wire logic oam_y1731,
  input wire logic [39:0] snap_pid,
  input wire logic [31:0] payload,
  input wire logic [31:0] ip4_sip,
  input wire logic [31:0] ip6_sip_lo,
  input wire logic [15:0] l4_dport,
  output logic etlen,
  output logic ipsnap,
  output logic ip4,
  output logic tcpudp,
  output logic tcp,
  output logic [7:0] proto,
  output logic [15:0] type_overload_field,
  output logic [31:0] sip
);
  logic is_ip;
  always_comb
  begin
    etlen = type_len >= fkx_pkg::TYPE_OVERLOAD_FIELD_MIN;
    ip4 = (type_len == fkx_pkg::TYPE_OVERLOAD_FIELD_IP4) &&
          (ip_version == fkx_pkg::IPVER_4);
    is_ip = ip4 || ((type_len == fkx_pkg::TYPE_OVERLOAD_FIELD_IP6) &&
            (ip_version == fkx_pkg::IPVER_6));
    ipsnap = etlen ? is_ip : (llc_hdr == fkx_pkg::LLC_SNAP);
    proto = ip4 ? ip4_proto : ip6_next_hdr;
    tcpudp = oam_y1731 || (is_ip && ((proto == fkx_pkg::PROTO_TCP) ||
             (proto == fkx_pkg::PROTO_UDP)));
    tcp = is_ip && (proto == fkx_pkg::PROTO_TCP);
    if (!etlen && !ipsnap)
    begin
      type_overload_field = llc_hdr[23:8];
      sip = {llc_hdr[7:0], payload[31:8]};
    end
    else if (!etlen)
    begin
      type_overload_field = snap_pid[39:24];
      sip = {snap_pid[23:0], payload[31:24]};
    end
    else if (ipsnap)
    begin
      type_overload_field = tcpudp ? l4_dport : {8'h00, proto};
      sip = ip4 ? ip4_sip : ip6_sip_lo;
    end
    else
    begin
      type_overload_field = type_len;
      sip = payload;
    end
  end
endmodule : fkx_classify
`default_nettype wire

// ==== rtl/fkx_pkg.sv ====
// Constants for the frame key field extractor.
// Assumes a 32-bit APB register bus and a parser giving decoded fields.
`default_nettype none
package fkx_pkg;
  // Register offsets and control fields
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int CTRL_DST_BIT = 0;
  localparam int CTRL_CLDSCP_BIT = 1;
  localparam int CTRL_KT_LSB = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Key types
  localparam logic [1:0] KT_LL_FULL = 2'h0;
  localparam logic [1:0] KT_NORMAL = 2'h1;
  localparam logic [1:0] KT_5TUPLE = 2'h2;
  // Field applicability masks, one bit per key field
  localparam int NFIELD = 17;
  localparam logic [16:0] MASK_LL = 17'h1BFF6;
  localparam logic [16:0] MASK_NORMAL = 17'h1AFFD;
  localparam logic [16:0] MASK_5TUPLE = 17'h1FE88;
  localparam int F_DST = 0;
  localparam int F_DMAC = 1;
  localparam int F_SMAC = 2;
  localparam int F_IPMC = 3;
  localparam int F_ETLEN = 4;
  localparam int F_TYPE_OVERLOAD_FIELD = 5;
  localparam int F_IPSNAP = 6;
  localparam int F_IP4 = 7;
  localparam int F_FRAG = 8;
  localparam int F_FRAGOFS = 9;
  localparam int F_OPT = 10;
  localparam int F_DSCP = 11;
  localparam int F_DIP = 12;
  localparam int F_SIP = 13;
  localparam int F_PROTO = 14;
  localparam int F_TCPUDP = 15;
  localparam int F_TCP = 16;
  // Frame decode constants
  localparam logic [15:0] TYPE_OVERLOAD_FIELD_MIN = 16'h0600;
  localparam logic [15:0] TYPE_OVERLOAD_FIELD_IP4 = 16'h0800;
  localparam logic [15:0] TYPE_OVERLOAD_FIELD_IP6 = 16'h86DD;
  localparam logic [3:0] IPVER_4 = 4'h4;
  localparam logic [3:0] IPVER_6 = 4'h6;
  localparam logic [23:0] LLC_SNAP = 24'hAAAA03;
  localparam logic [3:0] IP4_MC_TOP = 4'hE;
  localparam logic [7:0] IP6_MC_TOP = 8'hFF;
  localparam logic [3:0] IHL_BASE = 4'h5;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;
endpackage : fkx_pkg
`default_nettype wire

// ==== rtl/fkx_top.sv ====
// Key field extractor: registers the lookup key from parsed fields.
// Assumes the parser gives one frame's fields per in_valid cycle.
//
// The placing of the registers and the APB slave port were left to the implementer.
`default_nettype none
// Functional notes
// - Destination select swaps MAC sources, and IP sources for IP frames
// - IP multicast from address top bits
// - EtherType flag when type at least 600
// - LLC type field is DSAP and SSAP
// - SNAP type field is PID bytes 4-3
// - TCP_OR_UDP_FLAG IP frames use destination port
// - Other IP frames use protocol number
// - Other EtherType frames use EtherType
// - IP flag for 0800 v4, 86DD v6
// - SNAP flag for LLC AA AA 03
// - IPv4 flag needs 0800 and version 4
// - Fragmented when more-fragments or offset nonzero
// - Non-first fragment when offset nonzero
// - Options flag when header length above 5
// - DSCP from frame or classified DSCP
// - Destination IP is IPv4 or IPv6 low
// - LLC and SNAP source IP overloads
// - IP source IP is v4 or v6 low
// - Other frames source IP is payload 0-3
// - Protocol field is v4 proto or next header
// - TCP_OR_UDP_FLAG flag for 6, 17, or OAM
// - TCP flag only for protocol 6
module fkx_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic in_valid,
  input wire logic [47:0] frame_dmac,
  input wire logic [47:0] frame_smac,
  input wire logic [15:0] type_len,
  input wire logic [3:0] ip_version,
  input wire logic [23:0] llc_hdr,
  input wire logic [39:0] snap_pid,
  input wire logic [31:0] payload,
  input wire logic [31:0] ip4_sip,
  input wire logic [31:0] ip4_dip,
  input wire logic [31:0] ip6_sip_lo,
  input wire logic [31:0] ip6_dip_lo,
  input wire logic [7:0] ip6_dip_top,
  input wire logic [7:0] ip4_proto,
  input wire logic [7:0] ip6_next_hdr,
  input wire logic more_frag,
  input wire logic [12:0] frag_offset,
  input wire logic [3:0] ip4_hdr_len,
  input wire logic [5:0] frame_dscp,
  input wire logic [5:0] classified_dscp,
  input wire logic [15:0] l4_dport,
  input wire logic oam_y1731,
  output logic key_valid_q,
  output logic [1:0] key_type_q,
  output logic dst_entry_q,
  output logic [47:0] dest_mac_field_q,
  output logic [47:0] source_mac_field_q,
  output logic ip_multicast_flag_q,
  output logic ethertype_encoded_flag_q,
  output logic [15:0] type_overload_field_q,
  output logic ip_or_snap_flag_q,
  output logic ipv4_flag_q,
  output logic fragmented_flag_q,
  output logic non_first_fragment_flag_q,
  output logic ipv4_options_flag_q,
  output logic [5:0] dscp_key_field_q,
  output logic [31:0] dest_ip_field_q,
  output logic [31:0] source_ip_field_q,
  output logic [7:0] ip_protocol_field_q,
  output logic tcp_or_udp_flag_q,
  output logic tcp_flag_q
);
  logic [31:0] ctrl_q;
  logic [15:0] key_count_q;
  logic next_key_selector_dst;
  logic classified_dscp_select;
  logic [1:0] key_sel;
  logic etlen;
  logic ipsnap;
  logic ip4;
  logic tcpudp;
  logic tcp;
  logic [7:0] proto;
  logic [15:0] type_overload_field;
  logic [31:0] sip;
  logic [16:0] on;
  logic [31:0] dip;
  logic ipmc;

  // Field applicability for a key type
  function automatic logic [16:0] key_mask(input logic [1:0] kt);
    if (kt == fkx_pkg::KT_LL_FULL)
      key_mask = fkx_pkg::MASK_LL;
    else if (kt == fkx_pkg::KT_NORMAL)
      key_mask = fkx_pkg::MASK_NORMAL;
    else if (kt == fkx_pkg::KT_5TUPLE)
      key_mask = fkx_pkg::MASK_5TUPLE;
    else
      key_mask = 17'h00000;
  endfunction : key_mask

  assign next_key_selector_dst = ctrl_q[fkx_pkg::CTRL_DST_BIT];
  assign classified_dscp_select = ctrl_q[fkx_pkg::CTRL_CLDSCP_BIT];
  assign key_sel = ctrl_q[fkx_pkg::CTRL_KT_LSB +: 2];
  assign on = key_mask(key_sel);

  fkx_apb_regs u_regs (
    .clk(clk),
    .arst_n(arst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .key_count(key_count_q),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .ctrl_q(ctrl_q)
  );

  fkx_classify u_cls (
    .type_len(type_len),
    .ip_version(ip_version),
    .llc_hdr(llc_hdr),
    .ip4_proto(ip4_proto),
    .ip6_next_hdr(ip6_next_hdr),
    .oam_y1731(oam_y1731),
    .snap_pid(snap_pid),
    .payload(payload),
    .ip4_sip(ip4_sip),
    .ip6_sip_lo(ip6_sip_lo),
    .l4_dport(l4_dport),
    .etlen(etlen),
    .ipsnap(ipsnap),
    .ip4(ip4),
    .tcpudp(tcpudp),
    .tcp(tcp),
    .proto(proto),
    .type_overload_field(type_overload_field),
    .sip(sip)
  );

  assign dip = ip4 ? ip4_dip : ip6_dip_lo;
  assign ipmc = ip4 ? (ip4_dip[31:28] == fkx_pkg::IP4_MC_TOP) :
    (etlen && ipsnap && ip6_dip_top == fkx_pkg::IP6_MC_TOP);

  // Key valid and frame count
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      key_valid_q <= 1'b0;
      key_count_q <= 16'h0000;
    end
    else
    begin
      key_valid_q <= in_valid;
      if (in_valid)
        key_count_q <= key_count_q + 16'h0001;
    end
  end

  // Layer-2 fields
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      key_type_q <= 2'h0;
      dst_entry_q <= 1'b0;
      dest_mac_field_q <= 48'h0000_0000_0000;
      source_mac_field_q <= 48'h0000_0000_0000;
      ethertype_encoded_flag_q <= 1'b0;
      type_overload_field_q <= 16'h0000;
      ip_or_snap_flag_q <= 1'b0;
    end
    else if (in_valid)
    begin
      key_type_q <= key_sel;
      dst_entry_q <= on[fkx_pkg::F_DST] && next_key_selector_dst;
      dest_mac_field_q <= on[fkx_pkg::F_DMAC] ? frame_dmac :
        48'h0000_0000_0000;
      if (!on[fkx_pkg::F_SMAC])
        source_mac_field_q <= 48'h0000_0000_0000;
      else if (next_key_selector_dst)
        source_mac_field_q <= frame_dmac;
      else
        source_mac_field_q <= frame_smac;
      ethertype_encoded_flag_q <= on[fkx_pkg::F_ETLEN] && etlen;
      type_overload_field_q <= on[fkx_pkg::F_TYPE_OVERLOAD_FIELD] ? type_overload_field : 16'h0000;
      ip_or_snap_flag_q <= on[fkx_pkg::F_IPSNAP] && ipsnap;
    end
  end

  // Layer-3 and layer-4 fields
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ip_multicast_flag_q <= 1'b0;
      ipv4_flag_q <= 1'b0;
      fragmented_flag_q <= 1'b0;
      non_first_fragment_flag_q <= 1'b0;
      ipv4_options_flag_q <= 1'b0;
      dscp_key_field_q <= 6'h00;
      dest_ip_field_q <= 32'h0000_0000;
      source_ip_field_q <= 32'h0000_0000;
      ip_protocol_field_q <= 8'h00;
      tcp_or_udp_flag_q <= 1'b0;
      tcp_flag_q <= 1'b0;
    end
    else if (in_valid)
    begin
      ip_multicast_flag_q <= on[fkx_pkg::F_IPMC] && ipmc;
      ipv4_flag_q <= on[fkx_pkg::F_IP4] && ip4;
      fragmented_flag_q <= on[fkx_pkg::F_FRAG] && ip4 &&
        (more_frag || frag_offset != 13'h0000);
      non_first_fragment_flag_q <= on[fkx_pkg::F_FRAGOFS] && ip4 &&
        (frag_offset != 13'h0000);
      ipv4_options_flag_q <= on[fkx_pkg::F_OPT] && ip4 &&
        (ip4_hdr_len > fkx_pkg::IHL_BASE);
      if (!on[fkx_pkg::F_DSCP])
        dscp_key_field_q <= 6'h00;
      else if (classified_dscp_select)
        dscp_key_field_q <= classified_dscp;
      else
        dscp_key_field_q <= frame_dscp;
      dest_ip_field_q <= on[fkx_pkg::F_DIP] ? dip : 32'h0000_0000;
      if (!on[fkx_pkg::F_SIP])
        source_ip_field_q <= 32'h0000_0000;
      else if (next_key_selector_dst && etlen && ipsnap)
        source_ip_field_q <= dip;
      else
        source_ip_field_q <= sip;
      ip_protocol_field_q <= on[fkx_pkg::F_PROTO] ? proto : 8'h00;
      tcp_or_udp_flag_q <= on[fkx_pkg::F_TCPUDP] && tcpudp;
      tcp_flag_q <= on[fkx_pkg::F_TCP] && tcp;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_valid_lat;
    in_valid |=> key_valid_q;
  endproperty
  a_valid_lat: assert property (p_valid_lat)
    else $error("key valid not one cycle after input");

  property p_swap_mac;
    in_valid && next_key_selector_dst && on[fkx_pkg::F_SMAC]
      |=> source_mac_field_q == $past(frame_dmac);
  endproperty
  a_swap_mac: assert property (p_swap_mac)
    else $error("source mac not swapped to destination");

  property p_etlen;
    in_valid && key_sel == fkx_pkg::KT_NORMAL
      |=> ethertype_encoded_flag_q ==
        ($past(type_len) >= fkx_pkg::TYPE_OVERLOAD_FIELD_MIN);
  endproperty
  a_etlen: assert property (p_etlen)
    else $error("ethertype flag wrong");

  property p_ip4;
    in_valid ##1 ipv4_flag_q |-> $past(type_len) == fkx_pkg::TYPE_OVERLOAD_FIELD_IP4 &&
      $past(ip_version) == fkx_pkg::IPVER_4;
  endproperty
  a_ip4: assert property (p_ip4)
    else $error("ipv4 flag set for non ipv4 frame");

  property p_nonfirst;
    ##1 non_first_fragment_flag_q |-> fragmented_flag_q ||
      key_type_q == fkx_pkg::KT_5TUPLE;
  endproperty
  a_nonfirst: assert property (p_nonfirst)
    else $error("non-first fragment without fragmented flag");

  property p_opts;
    in_valid && on[fkx_pkg::F_OPT] && ip4 && ip4_hdr_len > 4'h5
      |=> ipv4_options_flag_q;
  endproperty
  a_opts: assert property (p_opts)
    else $error("options flag missing");

  property p_dscp;
    in_valid && on[fkx_pkg::F_DSCP]
      |=> dscp_key_field_q == ($past(classified_dscp_select) ?
        $past(classified_dscp) : $past(frame_dscp));
  endproperty
  a_dscp: assert property (p_dscp)
    else $error("dscp source wrong");

  property p_tcp;
    ##1 tcp_flag_q |-> tcp_or_udp_flag_q;
  endproperty
  a_tcp: assert property (p_tcp)
    else $error("tcp flag without tcp or udp flag");

  property p_oam;
    in_valid && oam_y1731 && on[fkx_pkg::F_TCPUDP] |=> tcp_or_udp_flag_q;
  endproperty
  a_oam: assert property (p_oam)
    else $error("oam frame without forced flag");

  property p_hold;
    !in_valid |=> $stable(type_overload_field_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("key changed without input");

  property p_ipmc;
    in_valid && on[fkx_pkg::F_IPMC] && ip4
      |=> ip_multicast_flag_q ==
        ($past(ip4_dip[31:28]) == fkx_pkg::IP4_MC_TOP);
  endproperty
  a_ipmc: assert property (p_ipmc)
    else $error("ip multicast flag wrong for ipv4");

  property p_frag;
    in_valid && on[fkx_pkg::F_FRAG] && ip4 && more_frag
      |=> fragmented_flag_q;
  endproperty
  a_frag: assert property (p_frag)
    else $error("fragmented flag missing");

  property p_proto;
    in_valid && on[fkx_pkg::F_PROTO]
      |=> ip_protocol_field_q == (ipv4_flag_q ?
        $past(ip4_proto) : $past(ip6_next_hdr));
  endproperty
  a_proto: assert property (p_proto)
    else $error("protocol field from wrong source");

  c_swap: cover property (in_valid && next_key_selector_dst ##1 key_valid_q);
  c_snap: cover property (in_valid && !etlen && ipsnap);
  c_frag: cover property (##1 non_first_fragment_flag_q);
  c_oam: cover property (in_valid && oam_y1731);
  c_ip6: cover property (in_valid && etlen && ipsnap && !ip4);
endmodule : fkx_top
`default_nettype wire

// ==== tb/fkx_parser_model.sv ====
// Frame parser stand-in: turns a frame kind into type and LLC fields.
// Assumes kind is driven from the bench right after a clock edge.
`default_nettype none
module fkx_parser_model (
  input wire logic [2:0] kind,
  output logic [15:0] type_len,
  output logic [3:0] ip_version,
  output logic [23:0] llc_hdr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Kinds: LLC, SNAP, IPv4, IPv6, other, 0800 with version 6
  always_comb
  begin
    type_len = 16'h0600;
    ip_version = 4'h4;
    llc_hdr = 24'h4243C0;
    case (kind)
      3'h0: type_len = 16'h0040;
      3'h1:
      begin
        type_len = 16'h05FF;
        llc_hdr = 24'hAAAA03;
      end
      3'h2: type_len = 16'h0800;
      3'h3:
      begin
        type_len = 16'h86DD;
        ip_version = 4'h6;
      end
      3'h5:
      begin
        type_len = 16'h0800;
        ip_version = 4'h6;
      end
      default: type_len = 16'h0600;
    endcase
  end
endmodule : fkx_parser_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench for the key field extractor.
// Assumes APB with no wait states and a parser stand-in for type fields.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, in_valid = 1'b0, more_frag = 1'b0;
  logic oam_y1731 = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [15:0] type_len, l4_dport = 16'h1F90;
  logic [3:0] ip_version, ip4_hdr_len = 4'h5;
  logic [23:0] llc_hdr;
  logic [47:0] frame_dmac = 48'hA1A2A3A4A5A6, frame_smac = 48'hB1B2B3B4B5B6;
  logic [39:0] snap_pid = 40'h0102030405;
  logic [31:0] payload = 32'hC1C2C3C4, ip4_sip = 32'h0A000001;
  logic [31:0] ip6_sip_lo = 32'h0B000002, ip4_dip = 32'h0C000003;
  logic [31:0] ip6_dip_lo = 32'h0D000004;
  logic [7:0] ip6_dip_top = 8'h20, ip4_proto = 8'h01, ip6_next_hdr = 8'h01;
  logic [12:0] frag_offset = 13'h0000;
  logic [5:0] frame_dscp = 6'h15, classified_dscp = 6'h2A;
  logic key_valid_q, dst_entry_q, ip_multicast_flag_q;
  logic ethertype_encoded_flag_q, ip_or_snap_flag_q, ipv4_flag_q;
  logic fragmented_flag_q, non_first_fragment_flag_q, ipv4_options_flag_q;
  logic tcp_or_udp_flag_q, tcp_flag_q;
  logic [1:0] key_type_q;
  logic [47:0] dest_mac_field_q, source_mac_field_q;
  logic [15:0] type_overload_field_q;
  logic [5:0] dscp_key_field_q;
  logic [31:0] dest_ip_field_q, source_ip_field_q;
  logic [7:0] ip_protocol_field_q;
  int bad_count = 0, total_checks = 0, nsent = 0;
  // Expected flags {etlen,ipsnap,ip4}, type field, source IP per kind
  logic [2:0] xf [6] = '{3'h0, 3'h2, 3'h7, 3'h6, 3'h4, 3'h4};
  logic [15:0] xt [6] = '{16'h4243, 16'h0102, 16'h0001, 16'h0001,
    16'h0600, 16'h0800};
  logic [31:0] xs [6] = '{32'hC0C1C2C3, 32'h030405C1, 32'h0A000001,
    32'h0B000002, 32'hC1C2C3C4, 32'hC1C2C3C4};

  fkx_parser_model fkx_parser_model_i (.kind, .type_len, .ip_version,
    .llc_hdr);
  fkx_top fkx_top_i (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .in_valid, .frame_dmac,
    .frame_smac, .type_len, .ip_version, .llc_hdr, .snap_pid, .payload,
    .ip4_sip, .ip4_dip, .ip6_sip_lo, .ip6_dip_lo, .ip6_dip_top, .ip4_proto,
    .ip6_next_hdr, .more_frag, .frag_offset, .ip4_hdr_len, .frame_dscp,
    .classified_dscp, .l4_dport, .oam_y1731, .key_valid_q, .key_type_q,
    .dst_entry_q, .dest_mac_field_q, .source_mac_field_q,
    .ip_multicast_flag_q, .ethertype_encoded_flag_q,
    .type_overload_field_q, .ip_or_snap_flag_q, .ipv4_flag_q,
    .fragmented_flag_q, .non_first_fragment_flag_q, .ipv4_options_flag_q,
    .dscp_key_field_q, .dest_ip_field_q, .source_ip_field_q,
    .ip_protocol_field_q, .tcp_or_udp_flag_q, .tcp_flag_q);

  initial
  begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [47:0] x,
    input logic [47:0] g);
    total_checks++;
    if (g !== x)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_ctrl(input logic [1:0] kt, input logic cl,
    input logic dst);
    logic [31:0] r;
    logic e;
    apb(1'b1, fkx_pkg::CTRL_OFS, {28'h0000000, kt, cl, dst}, r, e);
  endtask : set_ctrl

  // Called right after an edge; one frame, then the key is judged
  task automatic send(input logic [2:0] k);
    kind <= k;
    in_valid <= 1'b1;
    @(posedge clk);
    in_valid <= 1'b0;
    nsent++;
    #1 chk("key_valid", 48'h1, key_valid_q);
    @(posedge clk);
    #1 chk("key_valid_end", 48'h0, key_valid_q);
  endtask : send

  task automatic t_regs(input logic [15:0] cnt, input logic [31:0] xc);
    logic [31:0] r;
    logic e;
    apb(1'b0, fkx_pkg::CTRL_OFS, 32'h0, r, e);
    chk("ctrl_read", xc, r);
    apb(1'b1, fkx_pkg::STAT_OFS, 32'hFFFF, r, e);
    apb(1'b0, fkx_pkg::STAT_OFS, 32'h0, r, e);
    chk("stat", {16'h0000, cnt}, r);
    apb(1'b0, 8'h08, 32'h0, r, e);
    chk("unmapped_err", 48'h1, e);
    chk("unmapped_data", 48'h0, r);
    apb(1'b1, fkx_pkg::CTRL_OFS, 32'hFFFFFFFF, r, e);
    apb(1'b0, fkx_pkg::CTRL_OFS, 32'h0, r, e);
    chk("ctrl_rw", 48'hF, r);
    @(posedge clk);
    send(3'h2);
    chk("key_type_none", 48'h3, key_type_q);
    chk("no_fields", 48'h0, {dst_entry_q, ipv4_flag_q,
      source_ip_field_q});
    $display("test regs done");
  endtask : t_regs

  task automatic t_types;
    set_ctrl(fkx_pkg::KT_LL_FULL, 1'b0, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk);
      send(3'(k));
      chk("etlen", xf[k][2], ethertype_encoded_flag_q);
      chk("ipsnap", xf[k][1], ip_or_snap_flag_q);
      chk("ipv4", xf[k][0], ipv4_flag_q);
      chk("type_overload_field", xt[k], type_overload_field_q);
      chk("sip", xs[k], source_ip_field_q);
      chk("dip", xf[k][0] ? ip4_dip : ip6_dip_lo, dest_ip_field_q);
      chk("dmac", frame_dmac, dest_mac_field_q);
      chk("key_type", fkx_pkg::KT_LL_FULL, key_type_q);
    end
    $display("test types done");
  endtask : t_types

  task automatic t_l4;
    logic [7:0] p;
    set_ctrl(fkx_pkg::KT_NORMAL, 1'b0, 1'b0);
    for (int j = 0; j < 6; j++)
    begin
      p = (j % 3 == 0) ? 8'h06 : (j % 3 == 1) ? 8'h11 : 8'h2F;
      @(posedge clk);
      ip4_proto <= p;
      ip6_next_hdr <= p;
      l4_dport <= {8'h50, p};
      send(j < 3 ? 3'h2 : 3'h3);
      chk("tcpudp", p != 8'h2F, tcp_or_udp_flag_q);
      chk("tcp", p == 8'h06, tcp_flag_q);
      chk("type_overload_field_l4", {8'h00, p == 8'h2F ? 8'h00 : 8'h50, p},
        type_overload_field_q);
    end
    @(posedge clk);
    oam_y1731 <= 1'b1;
    send(3'h4);
    chk("oam_tcpudp", 48'h1, tcp_or_udp_flag_q);
    chk("oam_tcp", 48'h0, tcp_flag_q);
    $display("test l4 done");
  endtask : t_l4

  task automatic t_frag;
    logic mf, v4;
    logic [12:0] ofs;
    logic [3:0] ihl;
    set_ctrl(fkx_pkg::KT_LL_FULL, 1'b0, 1'b0);
    for (int j = 0; j < 6; j++)
    begin
      mf = (j == 1 || j >= 4);
      ofs = (j == 2) ? 13'h0001 : (j > 3) ? 13'h1FFF : 13'h0000;
      ihl = (j == 3 || j == 5) ? 4'h6 : (j == 4) ? 4'hF : 4'h5;
      v4 = (j != 5);
      @(posedge clk);
      oam_y1731 <= 1'b0;
      more_frag <= mf;
      frag_offset <= ofs;
      ip4_hdr_len <= ihl;
      send(v4 ? 3'h2 : 3'h3);
      chk("frag", v4 && (mf || ofs != 0), fragmented_flag_q);
      chk("nonfirst", v4 && ofs != 0, non_first_fragment_flag_q);
      chk("options", v4 && ihl > 4'h5, ipv4_options_flag_q);
    end
    $display("test frag done");
  endtask : t_frag

  task automatic t_dst;
    set_ctrl(fkx_pkg::KT_NORMAL, 1'b0, 1'b1);
    @(posedge clk);
    frame_dmac <= 48'h0102030405FE;
    frame_smac <= 48'h0A0B0C0D0E0F;
    send(3'h2);
    chk("dst_entry", 48'h1, dst_entry_q);
    chk("smac_swap", 48'h0102030405FE, source_mac_field_q);
    chk("sip_swap", ip4_dip, source_ip_field_q);
    chk("dmac_absent", 48'h0, dest_mac_field_q);
    chk("dscp_frame", 48'h15, dscp_key_field_q);
    @(posedge clk);
    send(3'h4);
    chk("sip_nonip", payload, source_ip_field_q);
    set_ctrl(fkx_pkg::KT_NORMAL, 1'b1, 1'b0);
    @(posedge clk);
    send(3'h2);
    chk("dst_clear", 48'h0, dst_entry_q);
    chk("smac", 48'h0A0B0C0D0E0F, source_mac_field_q);
    chk("dscp_cl", 48'h2A, dscp_key_field_q);
    $display("test dst done");
  endtask : t_dst

  task automatic t_proto;
    set_ctrl(fkx_pkg::KT_5TUPLE, 1'b0, 1'b0);
    for (int j = 0; j < 4; j++)
    begin
      @(posedge clk);
      ip4_dip <= (j > 1) ? 32'hE0000001 : 32'hDFFFFFFF;
      ip6_dip_top <= (j > 1) ? 8'hFF : 8'hFE;
      ip4_proto <= 8'h2F;
      ip6_next_hdr <= 8'h3A;
      ip6_dip_lo <= 32'h0D0000F0;
      send((j % 2 == 1) ? 3'h3 : 3'h2);
      chk("ipmc", j > 1, ip_multicast_flag_q);
      chk("dip5", (j % 2 == 1) ? 32'h0D0000F0 : (j > 1) ? 32'hE0000001 :
        32'hDFFFFFFF, dest_ip_field_q);
      chk("proto", (j % 2 == 1) ? 8'h3A : 8'h2F, ip_protocol_field_q);
      chk("smac_absent", 48'h0, source_mac_field_q);
    end
    $display("test proto done");
  endtask : t_proto

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_regs(16'h0000, fkx_pkg::CTRL_RST);
    t_types;
    t_l4;
    t_frag;
    t_dst;
    t_proto;
    t_regs(16'(nsent), {28'h0000000, fkx_pkg::KT_5TUPLE, 2'h0});
    end_of_test;
  end

  initial
  begin
    #2000000;
    bad_count++;
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
